// ---- hdl/sbt_params.svh ----
// Register indices, field positions and reset values of the wide timer control.
// Assumes byte address = index * 4 on a 32-bit APB bus.
`ifndef SBT_PARAMS_SVH
`define SBT_PARAMS_SVH

// Register indices (byte address is four times these)
`define SBT_IDX_SHARED 6'h01
`define SBT_IDX_CTRL 6'h02
`define SBT_IDX_ENSYNC 6'h03
`define SBT_IDX_RELOAD 6'h10
`define SBT_IDX_CAPTURE 6'h11
`define SBT_IDX_IRQ_STAT 6'h12
`define SBT_IDX_IRQ_MASK 6'h13

// Shared control register fields
`define SBT_SH_MODE 7
`define SBT_SH_SELECT 6

// Wide timer control register fields
`define SBT_CT_RUN 7
`define SBT_CT_SINGLE 6
`define SBT_CT_TIMEOUT 5
`define SBT_CT_PRE_HI 4
`define SBT_CT_PRE_LO 3
`define SBT_CT_CAP_IE 2
`define SBT_CT_TO_IE 1
`define SBT_CT_ROUTE 0

// Enable and sync register fields
`define SBT_ES_WIDE_RUN 7
`define SBT_ES_NARROW_RUN 6
`define SBT_ES_SYNC 5
`define SBT_ES_RESERVED 5'h1F

// Interrupt status and mask fields
`define SBT_IRQ_TIMEOUT 0
`define SBT_IRQ_CAPTURE 1

// Reset values
`define SBT_RST_BYTE 8'h00
`define SBT_RST_PRESCALE 2'h0
`define SBT_RST_RELOAD 16'hFFFF
`define SBT_RST_IRQ 2'h0

`endif

// ---- hdl/sbt_pkg.sv ----
// Types shared by the wide timer control logic.
// Assumes nothing of its surroundings.
package sbt_pkg;

   // Operating mode of both counter/timers
   typedef enum logic {
      sbt_transmit,
      sbt_demod
   } sbt_mode_t;

   // Edge acceptance state in demodulation mode
   typedef enum logic [1:0] {
      sbt_cap_armed,
      sbt_cap_done
   } sbt_cap_t;

endpackage

// ---- hdl/sbt_sync.sv ----
// Two-flop synchroniser for a group of pin inputs.
// Assumes inputs are asynchronous to pclk.
`timescale 1ns/1ps
`default_nettype none

module sbt_sync #(
   parameter int WIDTH = 2
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);

   // Elaboration check of the width
   if (WIDTH < 1) begin : g_bad_width
      $error("sbt_sync: WIDTH must be at least 1");
   end

   // One flop pair per bit; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic stage1;
         logic stage2;
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               stage1 <= 1'b0;
               stage2 <= 1'b0;
            end else begin
               stage1 <= async_in[i];
               stage2 <= stage1;
            end
         end
         assign sync_out[i] = stage2;
      end
   endgenerate

endmodule

`default_nettype wire

// ---- hdl/sbt_wide_timer_ctl.sv ----
// Control logic of the sixteen-bit counter/timer with APB register access.
// Assumes an APB master on pclk, pins synchronised here, narrow timer outside.
//
// Contract
// - Shared mode bit selects transmit or demodulation
// - Transmit: select bit routes combined output pin
// - Demodulation: select bit picks input pin
// - Port3 bit1 input capture also raises request two
// - Bit 7 starts, stops, reads wide run
// - Transmit bit 6: reload or stop at terminal
// - Demodulation bit 6: every edge or first only
// - Timeout flag set at terminal, write-one clears
// - Bits 4:3 divide clock by 1,2,4,8
// - Bit 2 enables capture interrupt
// - Bit 1 enables timeout interrupt
// - Bit 0 routes wide output to pin
// - Prescale, capture mask survive stop recovery
// - Shared enable register mirrors both runs, sync
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_params.svh"

module sbt_wide_timer_ctl #(
   parameter int ADDR_W = 8,
   parameter int CNT_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stop_recovery,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic port2_bit0,
   input wire logic port3_bit1,
   input wire logic port3_bit5_data,
   input wire logic port3_bit6_data,
   input wire logic combined_timer_out,
   output logic port3_bit5,
   output logic port3_bit6,
   output logic wide_out,
   output logic narrow_counter_run,
   output logic external_request_two,
   output logic irq
);

   // Elaboration check of the parameters
   if (ADDR_W < 8 || CNT_W != 16) begin : g_bad_param
      $error("sbt_wide_timer_ctl: ADDR_W >= 8 and CNT_W == 16 required");
   end

   // Control state
   sbt_pkg::sbt_mode_t mode;
   logic select_bit;
   logic wide_counter_run;
   logic single_pass;
   logic timeout_flag;
   logic [1:0] prescale_select;
   logic capture_ie;
   logic timeout_ie;
   logic wide_output_route;
   logic sync_mode;
   logic [CNT_W-1:0] reload_value;
   logic [CNT_W-1:0] count;
   logic [7:0] wide_capture_low;
   logic [7:0] wide_capture_high;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   logic [1:0] read_clear_bits;
   logic [2:0] divider;
   sbt_pkg::sbt_cap_t cap_state;
   logic input_prev;

   // Synchronised pins
   logic [1:0] pins_sync;
   logic port2_bit0_s;
   logic port3_bit1_s;

   sbt_sync #(
      .WIDTH(2)
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .async_in({port3_bit1, port2_bit0}),
      .sync_out(pins_sync)
   );

   assign port2_bit0_s = pins_sync[0];
   assign port3_bit1_s = pins_sync[1];

   // APB decode
   wire [5:0] reg_index = paddr[7:2];
   wire setup_phase = psel && !penable;
   wire access_phase = psel && penable;
   wire wr_en = access_phase && pwrite;
   wire hit_shared = (reg_index == `SBT_IDX_SHARED);
   wire hit_ctrl = (reg_index == `SBT_IDX_CTRL);
   wire hit_ensync = (reg_index == `SBT_IDX_ENSYNC);
   wire hit_reload = (reg_index == `SBT_IDX_RELOAD);
   wire hit_capture = (reg_index == `SBT_IDX_CAPTURE);
   wire hit_stat = (reg_index == `SBT_IDX_IRQ_STAT);
   wire hit_mask = (reg_index == `SBT_IDX_IRQ_MASK);
   wire hit_any = hit_shared || hit_ctrl || hit_ensync || hit_reload || hit_capture
                  || hit_stat || hit_mask;
   wire aligned = (paddr[1:0] == 2'h0);
   wire valid_addr = hit_any && aligned;
   wire wr_shared = wr_en && valid_addr && hit_shared;
   wire wr_ctrl = wr_en && valid_addr && hit_ctrl;
   wire wr_ensync = wr_en && valid_addr && hit_ensync;
   wire wr_reload = wr_en && valid_addr && hit_reload;
   wire wr_mask = wr_en && valid_addr && hit_mask;
   wire rd_stat_done = access_phase && !pwrite && valid_addr && hit_stat;

   // Always ready; unmapped or misaligned access is an error
   assign pready = 1'b1;
   assign pslverr = access_phase && !valid_addr;

   // Mode and prescale decode
   wire demod = (mode == sbt_pkg::sbt_demod);
   wire [2:0] pre_mask = (prescale_select == 2'h0) ? 3'h0 :
                         (prescale_select == 2'h1) ? 3'h1 :
                         (prescale_select == 2'h2) ? 3'h3 : 3'h7;
   wire tick = ((divider & pre_mask) == pre_mask);

   // Demodulation input selection and edge detect
   wire demod_in = select_bit ? port2_bit0_s : port3_bit1_s;
   wire edge_seen = demod && wide_counter_run && (demod_in != input_prev);
   wire edge_accept = edge_seen && (!single_pass || cap_state == sbt_pkg::sbt_cap_armed);
   wire terminal = wide_counter_run && tick && (count == '0);

   // Run bit writes from either register; sync start hits both same edge
   wire run_write = wr_ctrl || wr_ensync;
   wire run_wdata = wr_ctrl ? pwdata[`SBT_CT_RUN] : pwdata[`SBT_ES_WIDE_RUN];
   wire start_wide = run_write && run_wdata && !wide_counter_run;
   wire stop_single = terminal && !demod && single_pass;

   // Event pulses into the interrupt logic
   wire timeout_event = terminal;
   wire capture_event = edge_accept;
   wire [1:0] event_vec = {capture_event, timeout_event};

   // Shared mode register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode <= sbt_pkg::sbt_transmit;
         select_bit <= 1'b0;
      end else if (stop_recovery) begin
         mode <= sbt_pkg::sbt_transmit;
         select_bit <= 1'b0;
      end else if (wr_shared) begin
         mode <= pwdata[`SBT_SH_MODE] ? sbt_pkg::sbt_demod : sbt_pkg::sbt_transmit;
         select_bit <= pwdata[`SBT_SH_SELECT];
      end
   end

   // Control bits cleared by both resets
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         single_pass <= 1'b0;
         timeout_ie <= 1'b0;
         wide_output_route <= 1'b0;
      end else if (stop_recovery) begin
         single_pass <= 1'b0;
         timeout_ie <= 1'b0;
         wide_output_route <= 1'b0;
      end else if (wr_ctrl) begin
         single_pass <= pwdata[`SBT_CT_SINGLE];
         timeout_ie <= pwdata[`SBT_CT_TO_IE];
         wide_output_route <= pwdata[`SBT_CT_ROUTE];
      end
   end

   // Bits kept across stop recovery
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prescale_select <= `SBT_RST_PRESCALE;
         capture_ie <= 1'b0;
         sync_mode <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            prescale_select <= pwdata[`SBT_CT_PRE_HI:`SBT_CT_PRE_LO];
            capture_ie <= pwdata[`SBT_CT_CAP_IE];
         end
         if (wr_ensync) begin
            sync_mode <= pwdata[`SBT_ES_SYNC];
         end
      end
   end

   // Wide run bit: write 1 starts, 0 stops, single pass ends it in transmit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_counter_run <= 1'b0;
      end else if (stop_recovery) begin
         wide_counter_run <= 1'b0;
      end else if (run_write) begin
         wide_counter_run <= run_wdata;
      end else if (stop_single) begin
         wide_counter_run <= 1'b0;
      end
   end

   // Narrow run bit; sync start shares the wide start edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         narrow_counter_run <= 1'b0;
      end else if (stop_recovery) begin
         narrow_counter_run <= 1'b0;
      end else if (wr_ensync) begin
         narrow_counter_run <= pwdata[`SBT_ES_NARROW_RUN];
      end
   end

   // Timeout flag: set wins over write-one clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timeout_flag <= 1'b0;
      end else if (timeout_event) begin
         timeout_flag <= 1'b1;
      end else if (stop_recovery) begin
         timeout_flag <= 1'b0;
      end else if (wr_ctrl && pwdata[`SBT_CT_TIMEOUT]) begin
         timeout_flag <= 1'b0;
      end
   end

   // Reload value register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         reload_value <= `SBT_RST_RELOAD;
      end else if (wr_reload) begin
         reload_value <= pwdata[CNT_W-1:0];
      end
   end

   // Prescaler restarts with the counter so sync starts align
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divider <= 3'h0;
      end else if (start_wide || !wide_counter_run) begin
         divider <= 3'h0;
      end else begin
         divider <= divider + 3'h1;
      end
   end

   // Down counter: load on start, reload or stop at terminal, reload on edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count <= `SBT_RST_RELOAD;
      end else if (start_wide) begin
         count <= reload_value;
      end else if (edge_accept) begin
         count <= reload_value;
      end else if (terminal) begin
         count <= reload_value;
      end else if (wide_counter_run && tick) begin
         count <= count - 16'h0001;
      end
   end

   // Output level toggles at each terminal count in transmit mode
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_out <= 1'b0;
      end else if (stop_recovery) begin
         wide_out <= 1'b0;
      end else if (terminal && !demod) begin
         wide_out <= !wide_out;
      end
   end

   // Edge tracking and first-edge acceptance
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         input_prev <= 1'b0;
         cap_state <= sbt_pkg::sbt_cap_armed;
      end else begin
         input_prev <= demod_in;
         case (cap_state)
            sbt_pkg::sbt_cap_armed: begin
               if (edge_accept && single_pass) begin
                  cap_state <= sbt_pkg::sbt_cap_done;
               end
            end
            sbt_pkg::sbt_cap_done: begin
               if (start_wide || !single_pass) begin
                  cap_state <= sbt_pkg::sbt_cap_armed;
               end
            end
            default: begin
               cap_state <= sbt_pkg::sbt_cap_armed;
            end
         endcase
      end
   end

   // Capture of elapsed count on an accepted edge
   wire [CNT_W-1:0] elapsed = reload_value - count;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wide_capture_low <= 8'h00;
         wide_capture_high <= 8'h00;
      end else if (capture_event) begin
         wide_capture_low <= elapsed[7:0];
         wide_capture_high <= elapsed[15:8];
      end
   end

   // Request two on capture when the input is port3 bit1
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         external_request_two <= 1'b0;
      end else begin
         external_request_two <= capture_event && !select_bit;
      end
   end

   // Sticky interrupt status; events win over the read clear
   wire [1:0] ie_gate = {capture_ie, timeout_ie};
   wire [1:0] next_irq_status = (irq_status & ~(rd_stat_done ? read_clear_bits : 2'h0))
                                | (event_vec & ie_gate);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status <= `SBT_RST_IRQ;
         irq_mask <= `SBT_RST_IRQ;
      end else begin
         irq_status <= next_irq_status;
         if (wr_mask) begin
            irq_mask <= pwdata[1:0];
         end
      end
   end

   assign irq = |(irq_status & irq_mask);

   // Read mux for the setup cycle
   wire [7:0] rd_shared = {demod, select_bit, 6'h00};
   wire [7:0] rd_ctrl = {wide_counter_run, single_pass, timeout_flag, prescale_select,
                         capture_ie, timeout_ie, wide_output_route};
   wire [7:0] rd_ensync = {wide_counter_run, narrow_counter_run, sync_mode,
                           `SBT_ES_RESERVED};
   wire [31:0] rd_data = !valid_addr ? 32'h0000_0000 :
                         hit_shared ? {24'h000000, rd_shared} :
                         hit_ctrl ? {24'h000000, rd_ctrl} :
                         hit_ensync ? {24'h000000, rd_ensync} :
                         hit_reload ? {16'h0000, reload_value} :
                         hit_capture ? {16'h0000, wide_capture_high, wide_capture_low} :
                         hit_stat ? {30'h00000000, irq_status} :
                         {30'h00000000, irq_mask};

   // Read data latched at setup; only those status bits are cleared
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         read_clear_bits <= 2'h0;
      end else if (setup_phase && !pwrite) begin
         prdata <= rd_data;
         read_clear_bits <= irq_status;
      end
   end

   // Pin routing
   assign port3_bit5 = wide_output_route ? wide_out : port3_bit5_data;
   assign port3_bit6 = (!demod && select_bit) ? combined_timer_out : port3_bit6_data;

endmodule

`default_nettype wire

// ---- sim/sbt_pin_model.sv ----
// Far side of the block: demodulation input pins and ordinary port data.
// Assumes the pclk domain; port data comes from a 5-bit shift pattern stepped every cycle so no stale value passes.
`timescale 1ns/1ps
`default_nettype none
module sbt_pin_model (
   input wire logic pclk,
   input wire logic presetn,
   output logic port2_bit0,
   output logic port3_bit1,
   output logic port3_bit5_data,
   output logic port3_bit6_data,
   output logic combined_timer_out
);
   logic [4:0] shift;
   // Port data follows a 5-bit shift pattern that steps every cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift <= 5'h01;
      end else begin
         shift <= {shift[3:0], shift[4] ^ shift[2]};
      end
   end
   assign port3_bit5_data = shift[0];
   assign port3_bit6_data = shift[1];
   assign combined_timer_out = shift[3];
   initial begin
      port2_bit0 = 1'b0;
      port3_bit1 = 1'b0;
   end
   // Make one edge on the chosen demodulation input
   task automatic flip(input logic use_bit0);
      @(posedge pclk);
      if (use_bit0) begin
         port2_bit0 <= ~port2_bit0;
      end else begin
         port3_bit1 <= ~port3_bit1;
      end
   endtask
endmodule
`default_nettype wire

// ---- sim/sbt_wide_timer_ctl_sva.sv ----
// Port-level checks of the wide timer control.
// Assumes a bind onto sbt_wide_timer_ctl; shadows follow APB writes.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_params.svh"
module sbt_wide_timer_ctl_sva #(
   parameter int ADDR_W = 8
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic stop_recovery,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pslverr,
   input wire logic port3_bit5_data,
   input wire logic port3_bit6_data,
   input wire logic combined_timer_out,
   input wire logic port3_bit5,
   input wire logic port3_bit6,
   input wire logic wide_out,
   input wire logic narrow_counter_run,
   input wire logic external_request_two,
   input wire logic irq
);
   logic sh_mode;
   logic sh_sel;
   logic sh_route;
   logic [1:0] sh_mask;
   // Write decode
   wire logic wr = psel && penable && pwrite;
   wire logic wr_sh = wr && paddr == ADDR_W'({`SBT_IDX_SHARED, 2'h0});
   wire logic wr_ct = wr && paddr == ADDR_W'({`SBT_IDX_CTRL, 2'h0});
   wire logic wr_es = wr && paddr == ADDR_W'({`SBT_IDX_ENSYNC, 2'h0});
   wire logic wr_mk = wr && paddr == ADDR_W'({`SBT_IDX_IRQ_MASK, 2'h0});
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Shadows of mode, select, route and mask
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {sh_mode, sh_sel, sh_route, sh_mask} <= 5'h00;
      end else begin
         sh_mode <= !stop_recovery && (wr_sh ? pwdata[7] : sh_mode);
         sh_sel <= !stop_recovery && (wr_sh ? pwdata[6] : sh_sel);
         sh_route <= !stop_recovery && (wr_ct ? pwdata[0] : sh_route);
         sh_mask <= wr_mk ? pwdata[1:0] : sh_mask;
      end
   end
   property p_route;
      port3_bit5 == (sh_route ? wide_out : port3_bit5_data);
   endproperty
   a_route: assert property (p_route) else $error("pin 5 source wrong");
   property p_comb;
      port3_bit6 == ((!sh_mode && sh_sel) ? combined_timer_out : port3_bit6_data);
   endproperty
   a_comb: assert property (p_comb) else $error("pin 6 source wrong");
   property p_mask;
      sh_mask == 2'h0 |-> !irq;
   endproperty
   a_mask: assert property (p_mask) else $error("irq while all masked");
   property p_ext_src;
      external_request_two |-> sh_mode && !sh_sel;
   endproperty
   a_ext_src: assert property (p_ext_src) else $error("request two from wrong pin");
   property p_ext_pulse;
      external_request_two |=> !external_request_two;
   endproperty
   a_ext_pulse: assert property (p_ext_pulse) else $error("request two too long");
   property p_narrow;
      wr_es |=> narrow_counter_run == $past(pwdata[6]);
   endproperty
   a_narrow: assert property (p_narrow) else $error("narrow run not written");
   property p_sr;
      stop_recovery |=> !wide_out && !narrow_counter_run && port3_bit5 == port3_bit5_data;
   endproperty
   a_sr: assert property (p_sr) else $error("stop recovery left state");
   property p_tx_only;
      $changed(wide_out) && !$past(stop_recovery) |-> !$past(sh_mode);
   endproperty
   a_tx_only: assert property (p_tx_only) else $error("output moved in demod");
   property p_slverr;
      psel && penable && paddr[1:0] != 2'h0 |-> pslverr;
   endproperty
   a_slverr: assert property (p_slverr) else $error("misaligned access accepted");
   c_ext: cover property (external_request_two);
   c_irq: cover property (irq);
   c_tog: cover property ($changed(wide_out));
   c_err: cover property (pslverr);
endmodule
`default_nettype wire

// ---- sim/sixteen_bit_ir_timer_control_test.sv ----
// Self-checking bench of the wide timer control over APB.
// Assumes the pin model and checker are compiled before this file.
`timescale 1ns/1ps
`default_nettype none
`include "sbt_params.svh"
module sixteen_bit_ir_timer_control_test;
   localparam logic [7:0] A_SH = {`SBT_IDX_SHARED, 2'h0};
   localparam logic [7:0] A_CT = {`SBT_IDX_CTRL, 2'h0};
   localparam logic [7:0] A_ES = {`SBT_IDX_ENSYNC, 2'h0};
   localparam logic [7:0] A_RL = {`SBT_IDX_RELOAD, 2'h0};
   localparam logic [7:0] A_ST = {`SBT_IDX_IRQ_STAT, 2'h0};
   localparam logic [7:0] A_CP = {`SBT_IDX_CAPTURE, 2'h0};
   localparam logic [7:0] A_MK = {`SBT_IDX_IRQ_MASK, 2'h0};
   typedef struct {string nm; logic [31:0] e; logic [31:0] m; logic err;} sbt_note_t;
   logic pclk, presetn, stop_recovery, psel, penable, pwrite, pready, pslverr;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, seed, r;
   logic port2_bit0, port3_bit1, port3_bit5_data, port3_bit6_data, combined_timer_out;
   logic port3_bit5, port3_bit6, wide_out, narrow_counter_run, external_request_two, irq;
   int bad_count, samples_checked, cycles, ext_cnt, n, base;
   logic w0;
   sbt_note_t notes[$];
   sbt_note_t cur;
   sbt_wide_timer_ctl dut_u (.pclk, .presetn, .stop_recovery, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .port2_bit0, .port3_bit1,
      .port3_bit5_data, .port3_bit6_data, .combined_timer_out, .port3_bit5, .port3_bit6,
      .wide_out, .narrow_counter_run, .external_request_two, .irq);
   sbt_pin_model pins_u (.pclk, .presetn, .port2_bit0, .port3_bit1, .port3_bit5_data,
      .port3_bit6_data, .combined_timer_out);
   // Clock of 5 ns
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // One APB transfer; the expected result goes on the note queue
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      input logic [31:0] e, input logic [31:0] m, input logic err, input string nm);
      notes.push_back('{nm, e & m, m, err});
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d, 32'h0, 32'h0, 1'b0, "write");
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      xfer(1'b0, a, 32'h0, e, m, 1'b0, "read data");
   endtask
   task automatic wait_tog(output int k);
      k = 0;
      w0 = wide_out;
      do begin
         @(negedge pclk);
         k++;
      end while (wide_out === w0 && k < 400);
   endtask
   task automatic settle(input int k);
      repeat (k) @(negedge pclk);
   endtask
   // Watcher: compares finished transfers, counts pulses, cuts hangs
   always @(posedge pclk) begin
      cycles++;
      if (external_request_two === 1'b1) ext_cnt++;
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
         cur = notes.pop_front();
         chk(cur.nm, prdata & cur.m, cur.e);
         chk("slave error", {31'h0, pslverr}, {31'h0, cur.err});
      end
      if (cycles == 20000) begin
         bad_count++;
         close_out();
      end
   end
   initial begin
      {presetn, stop_recovery, psel, penable, pwrite, paddr, pwdata} = 45'h0;
      bad_count = 0;
      samples_checked = 0;
      cycles = 0;
      ext_cnt = 0;
      seed = 32'h0000D7C1;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rd(A_CT, 32'h00, 32'hFFFFFFFF);
      rd(A_ES, 32'h1F, 32'hFFFFFFFF);
      rd(A_SH, 32'h00, 32'hFFFFFFFF);
      rd(A_RL, 32'hFFFF, 32'hFFFFFFFF);
      xfer(1'b0, 8'h20, 32'h0, 32'h0, 32'hFFFFFFFF, 1'b1, "unmapped read");
      xfer(1'b1, 8'h09, 32'hFF, 32'h0, 32'h0, 1'b1, "misaligned write");
      $display("test reset finished");
      wr(A_MK, 32'h1);
      for (int p = 0; p < 4; p++) begin
         r = 32'h1 + xs() % 32'h6;
         wr(A_RL, r);
         wr(A_CT, 32'h83 | (p << 3));
         wait_tog(n);
         wait_tog(n);
         chk("toggle period", 32'(n), (r + 32'h1) << p);
         wr(A_CT, 32'h00);
      end
      settle(1);
      chk("irq raised", {31'h0, irq}, 32'h1);
      wr(A_MK, 32'h0);
      settle(1);
      chk("irq masked", {31'h0, irq}, 32'h0);
      wr(A_MK, 32'h1);
      rd(A_ST, 32'h1, 32'h1);
      settle(1);
      chk("irq cleared", {31'h0, irq}, 32'h0);
      rd(A_CT, 32'h20, 32'hFFFFFFFF);
      wr(A_CT, 32'h20);
      rd(A_CT, 32'h00, 32'hFFFFFFFF);
      wr(A_RL, 32'h4);
      wr(A_CT, 32'hC0);
      settle(30);
      rd(A_CT, 32'h60, 32'hFFFFFFFF);
      $display("test transmit finished");
      wr(A_CT, 32'h20);
      wr(A_ES, 32'hE0);
      rd(A_ES, 32'hFF, 32'hFFFFFFFF);
      rd(A_CT, 32'h80, 32'h80);
      wr(A_ES, 32'h20);
      rd(A_ES, 32'h3F, 32'hFFFFFFFF);
      $display("test sync finished");
      wr(A_SH, 32'h80);
      wr(A_RL, 32'h400);
      wr(A_MK, 32'h2);
      for (int s = 0; s < 2; s++) begin
         wr(A_CT, 32'h00);
         wr(A_CT, 32'h84 | (s << 6));
         base = ext_cnt;
         pins_u.flip(1'b0);
         n = 20 + xs() % 32'd30;
         repeat (n) @(posedge pclk);
         pins_u.flip(1'b0);
         settle(12);
         chk("request pulses", 32'(ext_cnt - base), s ? 32'h1 : 32'h2);
         chk("capture irq", {31'h0, irq}, 32'h1);
         rd(A_CP, s ? 32'h3 : 32'(n), 32'hFFFF);
         rd(A_ST, 32'h2, 32'h2);
      end
      wr(A_SH, 32'hC0);
      wr(A_CT, 32'h00);
      wr(A_CT, 32'h84);
      base = ext_cnt;
      pins_u.flip(1'b0);
      settle(12);
      rd(A_ST, 32'h0, 32'h2);
      pins_u.flip(1'b1);
      settle(12);
      chk("request pulses", 32'(ext_cnt - base), 32'h0);
      rd(A_ST, 32'h2, 32'h2);
      $display("test demodulation finished");
      wr(A_SH, 32'h40);
      wr(A_ES, 32'h20);
      wr(A_CT, 32'h9F);
      settle(5);
      @(posedge pclk);
      stop_recovery <= 1'b1;
      @(posedge pclk);
      stop_recovery <= 1'b0;
      rd(A_CT, 32'h1C, 32'hFFFFFFFF);
      rd(A_SH, 32'h00, 32'hFFFFFFFF);
      rd(A_ES, 32'h3F, 32'hFFFFFFFF);
      $display("test recovery finished");
      close_out();
   end
endmodule
bind sbt_wide_timer_ctl sbt_wide_timer_ctl_sva #(.ADDR_W(ADDR_W)) chk_u (.pclk, .presetn,
   .stop_recovery, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr, .port3_bit5_data,
   .port3_bit6_data, .combined_timer_out, .port3_bit5, .port3_bit6, .wide_out,
   .narrow_counter_run, .external_request_two, .irq);
`default_nettype wire
